// File: rfl_consts.vh
// timing, framing and table constants for the repeated frame radio link
`ifndef RFL_CONSTS_VH
`define RFL_CONSTS_VH

// ----------------------------------------
// clock and link timing
// ----------------------------------------
`define RFL_CLK_HZ 10000000
`define RFL_BAUD_BPS 2400
`define RFL_BIT_CYC (`RFL_CLK_HZ / `RFL_BAUD_BPS)
`define RFL_SAMPLE_NUM 3
`define RFL_SAMPLE_DEN 4
`define RFL_SAMPLE_CYC (`RFL_BIT_CYC * `RFL_SAMPLE_NUM / `RFL_SAMPLE_DEN)
`define RFL_GAP_BITS 48
`define RFL_GAP_CYC (`RFL_GAP_BITS * `RFL_BIT_CYC)
`define RFL_DWELL_MS 1000
`define RFL_DWELL_CYC (`RFL_DWELL_MS * (`RFL_CLK_HZ / 1000))
`define RFL_BP_HALF_US 10000
`define RFL_BP_CYC (`RFL_BP_HALF_US * (`RFL_CLK_HZ / 1000000))
`define RFL_CNT_W 24

// ----------------------------------------
// frame layout
// ----------------------------------------
`define RFL_FRAME_BITS 36
`define RFL_FIELD_BITS 12
`define RFL_SYM_BITS 6
`define RFL_PREAMBLE 12'hAAA
// postamble opens with a run of two, so a symbol next to it never makes a run above four
`define RFL_POSTAMBLE 12'hC3C
`define RFL_REPEATS 3'h4
`define RFL_MSG_COUNT 3'h5

`endif

// File: rfl_link.v
// repeated frame radio link: message sender, frame receiver and two-digit display drive
//
// What this block does
// - a frame is 36 bits: preamble, 12-bit data, postamble around the data
// - each data word is sent four times in a row, three for the first word after reset
// - each digit travels as one of sixteen 6-bit symbols, runs at most four
// - radio input shifts into a 3-bit history every clock
// - an edge in the low history bits enables the bit timer
// - timer reaches three quarters bit, input sampled into 36-bit frame register
// - without edges, sample again one bit period later
// - every new edge restarts the bit timer
// - postamble in top 12 bits stores data into next of four copies
// - after fourth copy, two equal copies accepted, decoded and displayed
// - symbol decoder maps 6-bit symbol to 4-bit value by table
// - segment decoder maps 4-bit value to 8-bit digit pattern
// - dwell counter pulses advance; a separate backplane counter toggles the display backplane
// - each message state picks two characters from the message table
// - advance increments message index, then reload is pulsed
// - reload pulsed exactly four times per state, spaced by the sequencer
// - gap counter spaces transmissions, repeat counter counts them
// - on reload in transmit role the sender captures the word and sends framed bits serially
// - in transmit role the radio control holds transmit mode
// - in receive role the radio control holds receive mode
// - bit timer terminal count follows clock and baud rate; its width is fixed at 24 bits
`timescale 1ns/100ps
`include "rfl_consts.vh"

module rfl_link
#(
	parameter [`RFL_CNT_W-1:0] BIT_CYC = `RFL_BIT_CYC,
	parameter [`RFL_CNT_W-1:0] SAMPLE_CYC = `RFL_SAMPLE_CYC,
	parameter [`RFL_CNT_W-1:0] GAP_CYC = `RFL_GAP_CYC,
	parameter [`RFL_CNT_W-1:0] DWELL_CYC = `RFL_DWELL_CYC,
	parameter [`RFL_CNT_W-1:0] BP_CYC = `RFL_BP_CYC
)
(
	input wire i_clk,
	input wire i_rst_n,
	input wire i_tx_role,
	input wire i_rf_rx,
	output reg o_rf_tx,
	output reg o_rf_control,
	output reg o_display_backplane,
	output reg [7:0] o_seg_hi,
	output reg [7:0] o_seg_lo,
	output reg o_rx_accept
);

// ----------------------------------------
// state codes
// ----------------------------------------
localparam [1:0] SND_IDLE = 2'b01;
localparam [1:0] SND_SEND = 2'b10;
localparam [2:0] SEQ_LOAD = 3'b001;
localparam [2:0] SEQ_GAP = 3'b010;
localparam [2:0] SEQ_IDLE = 3'b100;
localparam [5:0] FRAME_LAST = 6'h01;
localparam [31:0] FRAME_LEN = `RFL_FRAME_BITS;

// ----------------------------------------
// lookup functions
// ----------------------------------------
// symbols keep runs of at most two at each end, so no four-bit run is exceeded when joined
function [5:0] symbol_encoder;
	input [3:0] v;
	begin
		case (v)
			4'h0: symbol_encoder = 6'h0B;
			4'h1: symbol_encoder = 6'h0D;
			4'h2: symbol_encoder = 6'h13;
			4'h3: symbol_encoder = 6'h15;
			4'h4: symbol_encoder = 6'h16;
			4'h5: symbol_encoder = 6'h19;
			4'h6: symbol_encoder = 6'h1A;
			4'h7: symbol_encoder = 6'h1C;
			4'h8: symbol_encoder = 6'h23;
			4'h9: symbol_encoder = 6'h25;
			4'hA: symbol_encoder = 6'h26;
			4'hB: symbol_encoder = 6'h29;
			4'hC: symbol_encoder = 6'h2A;
			4'hD: symbol_encoder = 6'h2C;
			4'hE: symbol_encoder = 6'h32;
			default: symbol_encoder = 6'h34;
		endcase
	end
endfunction

function [3:0] symbol_decoder;
	input [5:0] s;
	begin
		case (s)
			6'h0B: symbol_decoder = 4'h0;
			6'h0D: symbol_decoder = 4'h1;
			6'h13: symbol_decoder = 4'h2;
			6'h15: symbol_decoder = 4'h3;
			6'h16: symbol_decoder = 4'h4;
			6'h19: symbol_decoder = 4'h5;
			6'h1A: symbol_decoder = 4'h6;
			6'h1C: symbol_decoder = 4'h7;
			6'h23: symbol_decoder = 4'h8;
			6'h25: symbol_decoder = 4'h9;
			6'h26: symbol_decoder = 4'hA;
			6'h29: symbol_decoder = 4'hB;
			6'h2A: symbol_decoder = 4'hC;
			6'h2C: symbol_decoder = 4'hD;
			6'h32: symbol_decoder = 4'hE;
			6'h34: symbol_decoder = 4'hF;
			default: symbol_decoder = 4'h0;
		endcase
	end
endfunction

// values 0-8 are digits, 9-F are the letters C o L r u n E
function [7:0] segment_decoder;
	input [3:0] v;
	begin
		case (v)
			4'h0: segment_decoder = 8'h3F;
			4'h1: segment_decoder = 8'h06;
			4'h2: segment_decoder = 8'h5B;
			4'h3: segment_decoder = 8'h4F;
			4'h4: segment_decoder = 8'h66;
			4'h5: segment_decoder = 8'h6D;
			4'h6: segment_decoder = 8'h7D;
			4'h7: segment_decoder = 8'h07;
			4'h8: segment_decoder = 8'h7F;
			4'h9: segment_decoder = 8'h39;
			4'hA: segment_decoder = 8'h5C;
			4'hB: segment_decoder = 8'h38;
			4'hC: segment_decoder = 8'h50;
			4'hD: segment_decoder = 8'h1C;
			4'hE: segment_decoder = 8'h54;
			default: segment_decoder = 8'h79;
		endcase
	end
endfunction

// message table: two characters per state
function [7:0] message_chars;
	input [2:0] idx;
	begin
		case (idx)
			3'h0: message_chars = 8'h9A;
			3'h1: message_chars = 8'hAB;
			3'h2: message_chars = 8'hCD;
			3'h3: message_chars = 8'hEE;
			default: message_chars = 8'hFC;
		endcase
	end
endfunction

// ----------------------------------------
// pin synchronisers and role
// ----------------------------------------
reg [1:0] role_sync;
reg [1:0] rx_sync;
wire tx_role;

assign tx_role = role_sync[1];

always @(posedge i_clk or negedge i_rst_n)
begin
	if (!i_rst_n)
	begin
		role_sync <= 2'h0;
		rx_sync <= 2'h0;
		o_rf_control <= 1'b0;
	end
	else
	begin
		role_sync <= {role_sync[0], i_tx_role};
		rx_sync <= {rx_sync[0], i_rf_rx};
		o_rf_control <= tx_role;
	end
end

// ----------------------------------------
// display timer and backplane
// ----------------------------------------
reg [`RFL_CNT_W-1:0] dwell_count;
reg [`RFL_CNT_W-1:0] bp_count;
reg advance;

always @(posedge i_clk or negedge i_rst_n)
begin
	if (!i_rst_n)
	begin
		dwell_count <= {`RFL_CNT_W{1'b0}};
		bp_count <= {`RFL_CNT_W{1'b0}};
		advance <= 1'b0;
		o_display_backplane <= 1'b0;
	end
	else
	begin
		advance <= 1'b0;
		if (dwell_count == DWELL_CYC - 1'b1)
		begin
			dwell_count <= {`RFL_CNT_W{1'b0}};
			advance <= 1'b1;
		end
		else
			dwell_count <= dwell_count + 1'b1;
		if (bp_count == BP_CYC - 1'b1)
		begin
			bp_count <= {`RFL_CNT_W{1'b0}};
			o_display_backplane <= ~o_display_backplane;
		end
		else
			bp_count <= bp_count + 1'b1;
	end
end

// ----------------------------------------
// load sequencer
// ----------------------------------------
reg [2:0] seq_state;
reg [2:0] message_index;
reg [2:0] repeat_counter;
reg [`RFL_CNT_W-1:0] gap_counter;
reg reload;
wire [7:0] tx_chars;
wire [`RFL_FIELD_BITS-1:0] message_word;

assign tx_chars = message_chars(message_index);
assign message_word = {symbol_encoder(tx_chars[7:4]), symbol_encoder(tx_chars[3:0])};

always @(posedge i_clk or negedge i_rst_n)
begin
	if (!i_rst_n)
	begin
		seq_state <= SEQ_LOAD;
		message_index <= 3'h0;
		repeat_counter <= 3'h0;
		gap_counter <= {`RFL_CNT_W{1'b0}};
		reload <= 1'b0;
	end
	else
	begin
		reload <= 1'b0;
		if (advance)
		begin
			message_index <= (message_index == `RFL_MSG_COUNT - 1'b1) ? 3'h0 : message_index + 1'b1;
			repeat_counter <= 3'h0;
			seq_state <= SEQ_LOAD;
		end
		else
		begin
			case (seq_state)
				SEQ_LOAD:
				begin
					reload <= 1'b1;
					repeat_counter <= repeat_counter + 1'b1;
					gap_counter <= {`RFL_CNT_W{1'b0}};
					seq_state <= SEQ_GAP;
				end
				SEQ_GAP:
				begin
					if (gap_counter == GAP_CYC - 1'b1)
						seq_state <= (repeat_counter == `RFL_REPEATS) ? SEQ_IDLE : SEQ_LOAD;
					else
						gap_counter <= gap_counter + 1'b1;
				end
				SEQ_IDLE:
					seq_state <= SEQ_IDLE;
				default:
					seq_state <= SEQ_IDLE;
			endcase
		end
	end
end

// ----------------------------------------
// serial sender
// ----------------------------------------
reg [1:0] snd_state;
reg [`RFL_FRAME_BITS-1:0] tx_shift;
reg [5:0] tx_bits_left;
reg [`RFL_CNT_W-1:0] tx_timer;
reg [`RFL_FRAME_BITS-1:0] tx_frame;

always @*
begin
	tx_frame = {`RFL_POSTAMBLE, message_word, `RFL_PREAMBLE};
end

// bit 0 goes first; the receiver refills from the top so the layout matches
always @(posedge i_clk or negedge i_rst_n)
begin
	if (!i_rst_n)
	begin
		snd_state <= SND_IDLE;
		tx_shift <= {`RFL_FRAME_BITS{1'b0}};
		tx_bits_left <= 6'h0;
		tx_timer <= {`RFL_CNT_W{1'b0}};
		o_rf_tx <= 1'b0;
	end
	else if (reload && tx_role)
	begin
		snd_state <= SND_SEND;
		tx_shift <= tx_frame;
		tx_bits_left <= FRAME_LEN[5:0];
		tx_timer <= {`RFL_CNT_W{1'b0}};
		o_rf_tx <= tx_frame[0];
	end
	else
	begin
		case (snd_state)
			SND_SEND:
			begin
				if (tx_timer == BIT_CYC - 1'b1)
				begin
					tx_timer <= {`RFL_CNT_W{1'b0}};
					tx_shift <= {1'b0, tx_shift[`RFL_FRAME_BITS-1:1]};
					tx_bits_left <= tx_bits_left - 1'b1;
					if (tx_bits_left == FRAME_LAST)
					begin
						snd_state <= SND_IDLE;
						o_rf_tx <= 1'b0;
					end
					else
						o_rf_tx <= tx_shift[1];
				end
				else
					tx_timer <= tx_timer + 1'b1;
			end
			SND_IDLE:
				o_rf_tx <= 1'b0;
			default:
				snd_state <= SND_IDLE;
		endcase
	end
end

// ----------------------------------------
// receiver bit timing
// ----------------------------------------
reg [2:0] receive_history;
reg rx_running;
reg [`RFL_CNT_W-1:0] rx_timer;
reg [`RFL_FRAME_BITS-1:0] rx_frame;
reg rx_sample;
wire rx_edge;

assign rx_edge = receive_history[1] ^ receive_history[0];

always @(posedge i_clk or negedge i_rst_n)
begin
	if (!i_rst_n)
	begin
		receive_history <= 3'h0;
		rx_running <= 1'b0;
		rx_timer <= {`RFL_CNT_W{1'b0}};
		rx_sample <= 1'b0;
	end
	else
	begin
		receive_history <= {receive_history[1:0], rx_sync[1]};
		rx_sample <= 1'b0;
		if (rx_edge)
		begin
			rx_running <= 1'b1;
			rx_timer <= SAMPLE_CYC - 1'b1;
		end
		else if (rx_running)
		begin
			if (rx_timer == {`RFL_CNT_W{1'b0}})
			begin
				rx_sample <= 1'b1;
				rx_timer <= BIT_CYC - 1'b1;
			end
			else
				rx_timer <= rx_timer - 1'b1;
		end
	end
end

// ----------------------------------------
// frame capture, copies and agreement
// ----------------------------------------
reg [`RFL_FIELD_BITS-1:0] copy_register [0:3];
reg [1:0] copy_index;
reg [7:0] rx_chars;
reg [`RFL_FRAME_BITS-1:0] next_frame;
reg frame_hit;
reg agree;
reg [`RFL_FIELD_BITS-1:0] agreed;
wire [`RFL_FIELD_BITS-1:0] rx_data;
wire [`RFL_FIELD_BITS-1:0] first_copy_register;

assign first_copy_register = copy_register[0];
assign rx_data = next_frame[23:12];

always @*
begin
	next_frame = {receive_history[0], rx_frame[`RFL_FRAME_BITS-1:1]};
	frame_hit = rx_sample && (next_frame[35:24] == `RFL_POSTAMBLE);
	agree = 1'b1;
	agreed = first_copy_register;
	if ((first_copy_register == copy_register[1]) || (first_copy_register == copy_register[2]) ||
		(first_copy_register == rx_data))
		agreed = first_copy_register;
	else if ((copy_register[1] == copy_register[2]) || (copy_register[1] == rx_data))
		agreed = copy_register[1];
	else if (copy_register[2] == rx_data)
		agreed = copy_register[2];
	else
		agree = 1'b0;
end

always @(posedge i_clk or negedge i_rst_n)
begin
	if (!i_rst_n)
	begin
		rx_frame <= {`RFL_FRAME_BITS{1'b0}};
		copy_index <= 2'h0;
		rx_chars <= 8'h00;
		o_rx_accept <= 1'b0;
		copy_register[0] <= 12'h000;
		copy_register[1] <= 12'h000;
		copy_register[2] <= 12'h000;
		copy_register[3] <= 12'h000;
	end
	else
	begin
		o_rx_accept <= 1'b0;
		if (frame_hit)
		begin
			rx_frame <= {`RFL_FRAME_BITS{1'b0}};
			copy_register[copy_index] <= rx_data;
			copy_index <= copy_index + 1'b1;
			if (copy_index == 2'h3 && agree)
			begin
				rx_chars <= {symbol_decoder(agreed[11:6]), symbol_decoder(agreed[5:0])};
				o_rx_accept <= 1'b1;
			end
		end
		else if (rx_sample)
			rx_frame <= next_frame;
	end
end

// ----------------------------------------
// display drive
// ----------------------------------------
reg [7:0] shown_chars;

always @*
begin
	shown_chars = tx_role ? tx_chars : rx_chars;
end

// lit segments are driven in antiphase to the backplane, unlit ones in phase, so the glass sees no DC
always @(posedge i_clk or negedge i_rst_n)
begin
	if (!i_rst_n)
	begin
		o_seg_hi <= 8'h00;
		o_seg_lo <= 8'h00;
	end
	else
	begin
		o_seg_hi <= segment_decoder(shown_chars[7:4]) ^ {8{o_display_backplane}};
		o_seg_lo <= segment_decoder(shown_chars[3:0]) ^ {8{o_display_backplane}};
	end
end

endmodule

// File: rfl_link_sva.sv
// port checker for the repeated frame radio link
`timescale 1ns/100ps
`include "rfl_consts.vh"
module rfl_link_sva
#(
	parameter [`RFL_CNT_W-1:0] BIT_CYC = `RFL_BIT_CYC,
	parameter [`RFL_CNT_W-1:0] BP_CYC = `RFL_BP_CYC
)
(
	input wire i_clk,
	input wire i_rst_n,
	input wire i_tx_role,
	input wire i_rf_rx,
	input wire o_rf_tx,
	input wire o_rf_control,
	input wire o_display_backplane,
	input wire [7:0] o_seg_hi,
	input wire [7:0] o_seg_lo,
	input wire o_rx_accept
);
	// ----------------------------------------
	// run lengths of backplane and transmit line
	// ----------------------------------------
	reg [`RFL_CNT_W-1:0] bp_run;
	reg [`RFL_CNT_W-1:0] tx_run;
	reg bp_q;
	reg tx_q;
	reg bp_seen;
	always @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			bp_run <= '0;
			tx_run <= '0;
			bp_q <= 1'b0;
			tx_q <= 1'b0;
			bp_seen <= 1'b0;
		end
		else
		begin
			bp_q <= o_display_backplane;
			tx_q <= o_rf_tx;
			bp_seen <= bp_seen | (o_display_backplane != bp_q);
			bp_run <= (o_display_backplane != bp_q) ? '0 : bp_run + 1'b1;
			tx_run <= (o_rf_tx != tx_q) ? '0 : tx_run + 1'b1;
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	a_ctrl_tx: assert property (i_tx_role [*4] |-> o_rf_control)
		else $error("radio control not in transmit mode");
	a_ctrl_rx: assert property (!i_tx_role [*4] |-> !o_rf_control)
		else $error("radio control not in receive mode");
	a_rx_quiet: assert property (!i_tx_role [*4] |-> !o_rf_tx)
		else $error("transmit line active in receive role");
	a_accept_pulse: assert property ($rose(o_rx_accept) |=> !o_rx_accept [*8])
		else $error("accept pulse too long");
	a_accept_role: assert property (o_rx_accept |-> !o_rf_control && !o_rf_tx)
		else $error("accept outside receive role");
	a_bp_period: assert property (bp_seen && o_display_backplane != bp_q |-> bp_run == BP_CYC - 1)
		else $error("backplane period wrong");
	a_bp_stall: assert property (bp_seen && o_display_backplane == bp_q |-> bp_run < BP_CYC - 1)
		else $error("backplane stalled");
	a_tx_bit_edge: assert property ($changed(o_rf_tx) && tx_run < 5 * BIT_CYC |-> (tx_run + 1) % BIT_CYC == 0)
		else $error("transmit bit length wrong");
	a_tx_run_max: assert property (o_rf_tx && tx_q |-> tx_run < 4 * BIT_CYC - 1)
		else $error("transmit run longer than four bits");
endmodule

bind rfl_link rfl_link_sva #(.BIT_CYC(BIT_CYC), .BP_CYC(BP_CYC)) i_rfl_link_sva (.i_clk(i_clk), .i_rst_n(i_rst_n),
	.i_tx_role(i_tx_role), .i_rf_rx(i_rf_rx), .o_rf_tx(o_rf_tx), .o_rf_control(o_rf_control),
	.o_display_backplane(o_display_backplane), .o_seg_hi(o_seg_hi), .o_seg_lo(o_seg_lo), .o_rx_accept(o_rx_accept));

// File: rfl_link_tb.sv
// self-checking bench for the repeated frame radio link
`timescale 1ns/100ps
`include "rfl_consts.vh"
module rfl_link_tb;
	localparam [`RFL_CNT_W-1:0] BC = 24'h10;
	localparam logic [5:0] SYM [16] = '{6'h0B, 6'h0D, 6'h13, 6'h15, 6'h16, 6'h19, 6'h1A, 6'h1C,
		6'h23, 6'h25, 6'h26, 6'h29, 6'h2A, 6'h2C, 6'h32, 6'h34};
	// digit patterns {dp,g..a}: 0-8, then C o L r u n E
	localparam logic [7:0] SEG [16] = '{8'h3F, 8'h06, 8'h5B, 8'h4F, 8'h66, 8'h6D, 8'h7D, 8'h07,
		8'h7F, 8'h39, 8'h5C, 8'h38, 8'h50, 8'h1C, 8'h54, 8'h79};
	logic i_clk;
	logic i_rst_n;
	logic i_tx_role;
	wire i_rf_rx;
	wire o_rf_tx;
	wire o_rf_control;
	wire o_display_backplane;
	wire [7:0] o_seg_hi;
	wire [7:0] o_seg_lo;
	wire o_rx_accept;
	int err_total;
	int n_tests;
	int cyc = 0;
	int acc = 0;
	logic [15:0] v;
	logic [35:0] f;

	rfl_link #(.BIT_CYC(BC), .SAMPLE_CYC(24'h0C), .GAP_CYC(24'h320), .DWELL_CYC(24'h1388), .BP_CYC(24'h32))
	i_rfl_link (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_tx_role(i_tx_role), .i_rf_rx(i_rf_rx), .o_rf_tx(o_rf_tx),
		.o_rf_control(o_rf_control), .o_display_backplane(o_display_backplane), .o_seg_hi(o_seg_hi),
		.o_seg_lo(o_seg_lo), .o_rx_accept(o_rx_accept));
	// the model's default bit length equals BC
	rfl_radio i_rfl_radio (.i_clk(i_clk), .i_mode_tx(o_rf_control), .o_rx(i_rf_rx));

	initial
	begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	always @(posedge i_clk)
	begin
		cyc++;
		acc += (o_rx_accept === 1'b1);
		if (cyc == 40000)
		begin
			err_total++;
			give_verdict();
		end
	end
	function automatic logic [11:0] wd(input logic [3:0] h, input logic [3:0] l);
		return {SYM[h], SYM[l]};
	endfunction
	function automatic logic [15:0] pt(input logic [3:0] h, input logic [3:0] l);
		return {SEG[h], SEG[l]};
	endfunction
	task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
		n_tests++;
		if (g !== e)
		begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rst(input logic role);
		@(negedge i_clk);
		i_rst_n = 1'b0;
		i_tx_role = role;
		repeat (10) @(negedge i_clk);
		i_rst_n = 1'b1;
	endtask
	// waits for the first rise (bit 1) and samples bits 1 to 35 mid-bit
	task automatic cap_frame(output logic [35:0] fr);
		logic p;
		int n;
		fr = '0;
		n = 0;
		do
		begin
			p = o_rf_tx;
			@(negedge i_clk);
			n++;
		end
		while (!(p === 1'b0 && o_rf_tx === 1'b1) && n < 4000);
		repeat (BC / 2) @(negedge i_clk);
		for (int i = 1; i < 36; i++)
		begin
			fr[i] = o_rf_tx;
			repeat (BC) @(negedge i_clk);
		end
	endtask
	task automatic pat(output logic [15:0] pv);
		logic b;
		do
		begin
			b = o_display_backplane;
			@(negedge i_clk);
		end
		while (b !== o_display_backplane);
		pv = {o_seg_hi, o_seg_lo} ^ {16{b}};
	endtask
	task automatic test_tx;
		rst(1'b1);
		for (int k = 0; k < 8; k++)
		begin
			cap_frame(f);
			chk("frame", {`RFL_POSTAMBLE, k < 3 ? wd(9, 10) : k < 7 ? wd(10, 11) : wd(12, 13), `RFL_PREAMBLE}, f);
			if (k == 0 || k == 3)
			begin
				pat(v);
				chk("display", k == 0 ? pt(9, 10) : pt(10, 11), v);
			end
		end
		chk("control", 1, o_rf_control);
		chk("accepts", 0, acc);
		$display("transmit test done");
	endtask
	task automatic test_rx;
		rst(1'b0);
		repeat (4) i_rfl_radio.send(wd(9, 10));
		chk("control", 0, o_rf_control);
		chk("accepts", 1, acc);
		pat(v);
		chk("display", pt(9, 10), v);
		for (int k = 1; k < 5; k++)
			i_rfl_radio.send(12'h111 * k);
		chk("accepts", 1, acc);
		pat(v);
		chk("display", pt(9, 10), v);
		i_rfl_radio.send(12'h123);
		i_rfl_radio.send(wd(10, 11));
		i_rfl_radio.send(12'h456);
		i_rfl_radio.send(wd(10, 11));
		chk("accepts", 2, acc);
		pat(v);
		chk("display", pt(10, 11), v);
		$display("receive test done");
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		i_rst_n = 1'b0;
		i_tx_role = 1'b1;
		err_total = 0;
		n_tests = 0;
		test_tx();
		test_rx();
		give_verdict();
	end
endmodule

// File: rfl_radio.sv
// radio module model that puts framed words on the receive line
`timescale 1ns/100ps
`include "rfl_consts.vh"
module rfl_radio
#(
	parameter [`RFL_CNT_W-1:0] BIT_CYC = 24'h10
)
(
	input wire i_clk,
	input wire i_mode_tx,
	output logic o_rx
);
	initial o_rx = 1'b0;
	// ----------------------------------------
	// one framed word, then a toggling idle tail
	// ----------------------------------------
	task automatic send(input logic [11:0] word);
		logic [35:0] frame;
		frame = {`RFL_POSTAMBLE, word, `RFL_PREAMBLE};
		@(negedge i_clk);
		for (int i = 0; i < 44; i++)
		begin
			// a module in transmit mode hears nothing but noise
			o_rx = (i < 36 && !i_mode_tx) ? frame[i] : ~o_rx;
			repeat (BIT_CYC) @(negedge i_clk);
		end
	endtask
endmodule
